// File: crbu_branch_unit.sv
`timescale 1ns/1ps
// Contract
// - Upper byte E5 is branch-if-no-overflow, E1 branch-if-nonzero; low byte offset.
// - No-overflow branch taken only while overflow flag is zero.
// - Nonzero branch taken only while zero flag is zero.
// - Target is incremented PC plus twice the signed 8-bit offset.
// - Taken branch lasts two cycles, second a no-op; untaken lasts one.
module crbu_branch_unit #(
    parameter int PC_W = crbu_pkg::PC_W
) (
    input wire logic clock,
    input wire logic reset,
    input wire logic clock_enable,
    input wire crbu_pkg::crbu_instr_t instr,
    input wire logic [PC_W-1:0] pc_incremented,
    input wire logic flag_overflow,
    input wire logic flag_zero,
    output crbu_pkg::crbu_phase_t phase,
    output logic busy,
    output logic is_branch,
    output logic taken,
    output logic nop_cycle,
    output logic flush_fetch,
    output crbu_pkg::crbu_pc_wr_t pc_wr,
    output logic flags_write
);
    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef struct packed {
        crbu_pkg::crbu_phase_t phase;
        logic second;          // In the no-operation cycle of a taken branch
        logic branch;          // Current word is one of our branches
        logic is_no_ovf;
        logic take;
        logic [7:0] offset;
        logic pc_write;
    } crbu_state_t;

    crbu_state_t state_reg;
    crbu_state_t state_next;
    logic [PC_W-1:0] target;
    logic load_target;

    // Elaboration check: the write request struct is sized by the package
    if (PC_W != crbu_pkg::PC_W) begin : g_pc_w_check
        $error("PC_W must match package PC width");
    end

    // ------------------------------------------------------------------
    // Target arithmetic, registered during the process phase
    // ------------------------------------------------------------------
    crbu_target_adder #(
        .PC_W(PC_W)
    ) u_adder (
        .clock(clock),
        .reset(reset),
        .clock_enable(clock_enable),
        .load(load_target),
        .pc_next(pc_incremented),
        .offset(state_reg.offset),
        .target(target)
    );

    // ------------------------------------------------------------------
    // Phase sequencing and decode
    // ------------------------------------------------------------------
    // Decode in phase one, latch literal in two, evaluate in three, write in four
    always_comb begin
        state_next = state_reg;
        state_next.pc_write = 1'b0;
        load_target = 1'b0;
        unique case (state_reg.phase)
            crbu_pkg::CRBU_PH_DECODE: begin
                state_next.phase = crbu_pkg::CRBU_PH_LITERAL;
                if (!state_reg.second) begin
                    // Only decode when the fetch stage presents a word
                    state_next.branch = instr.valid &&
                        ((instr.word[crbu_pkg::OP_HI:crbu_pkg::OP_LO] ==
                          crbu_pkg::OP_NO_OVERFLOW) ||
                         (instr.word[crbu_pkg::OP_HI:crbu_pkg::OP_LO] ==
                          crbu_pkg::OP_NONZERO));
                    state_next.is_no_ovf = instr.word[crbu_pkg::OP_HI:crbu_pkg::OP_LO] ==
                        crbu_pkg::OP_NO_OVERFLOW;
                    state_next.take = 1'b0;
                end
            end
            crbu_pkg::CRBU_PH_LITERAL: begin
                state_next.phase = crbu_pkg::CRBU_PH_PROCESS;
                if (state_reg.branch && !state_reg.second) begin
                    state_next.offset = instr.word[crbu_pkg::OFS_HI:crbu_pkg::OFS_LO];
                end
            end
            crbu_pkg::CRBU_PH_PROCESS: begin
                state_next.phase = crbu_pkg::CRBU_PH_WRITE;
                if (state_reg.branch && !state_reg.second) begin
                    // Flags are sampled here, after any preceding write settled
                    state_next.take = state_reg.is_no_ovf ? !flag_overflow
                                                          : !flag_zero;
                    load_target = 1'b1;
                end
            end
            crbu_pkg::CRBU_PH_WRITE: begin
                state_next.phase = crbu_pkg::CRBU_PH_DECODE;
                if (state_reg.second) begin
                    // Second cycle done: return to normal decoding
                    state_next.second = 1'b0;
                    state_next.branch = 1'b0;
                    state_next.take = 1'b0;
                end else if (state_reg.branch && state_reg.take) begin
                    state_next.pc_write = 1'b1;
                    state_next.second = 1'b1;
                end
            end
        endcase
    end

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            state_reg <= '{phase: crbu_pkg::CRBU_PH_DECODE, default: '0};
        end else if (clock_enable) begin
            state_reg <= state_next;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    // PC write is a one-clock pulse right after the write phase edge
    assign phase = state_reg.phase;
    assign busy = state_reg.branch || state_reg.second;
    assign is_branch = state_reg.branch && !state_reg.second;
    assign taken = state_reg.take;
    assign nop_cycle = state_reg.second;
    assign flush_fetch = state_reg.pc_write;
    assign pc_wr.write = state_reg.pc_write;
    assign pc_wr.target = target;
    assign flags_write = 1'b0;
endmodule : crbu_branch_unit

// File: crbu_branch_unit_tb.sv
`timescale 1ns/1ps
module crbu_branch_unit_tb;
    typedef struct packed {logic v; logic [15:0] w; logic o; logic z; logic [20:0] pc;
        logic br; logic tk; logic [20:0] tg;} crbu_row_t;
    logic clock = 1'b0;
    logic reset = 1'b1;
    crbu_pkg::crbu_instr_t instr = '0;
    logic [20:0] pc = '0;
    logic ovf = 1'b0;
    logic zero = 1'b0;
    crbu_pkg::crbu_phase_t phase;
    logic busy, is_branch, taken, nop_cycle, flush_fetch, flags_write;
    crbu_pkg::crbu_pc_wr_t pc_wr;
    int mismatches = 0;
    int n_tests = 0;
    // Word, flags, pc, then expected branch, taken and target; last row is taken so
    // the mid-run reset lands in its no-op cycle
    crbu_row_t rows [9] = '{
        '{1'h1, 16'hE57F, 1'h0, 1'h0, 21'h00_1000, 1'h1, 1'h1, 21'h00_10FE},
        '{1'h1, 16'hE580, 1'h1, 1'h0, 21'h00_1000, 1'h1, 1'h0, 21'h00_0000},
        '{1'h1, 16'hE500, 1'h0, 1'h1, 21'h1F_FFFE, 1'h1, 1'h1, 21'h1F_FFFE},
        '{1'h1, 16'hE180, 1'h1, 1'h0, 21'h00_0100, 1'h1, 1'h1, 21'h00_0000},
        '{1'h1, 16'hE101, 1'h0, 1'h1, 21'h00_0200, 1'h1, 1'h0, 21'h00_0000},
        '{1'h1, 16'hE1FF, 1'h1, 1'h0, 21'h00_0000, 1'h1, 1'h1, 21'h1F_FFFE},
        '{1'h0, 16'hE17F, 1'h0, 1'h0, 21'h00_0300, 1'h0, 1'h0, 21'h00_0000},
        '{1'h1, 16'hE310, 1'h0, 1'h0, 21'h00_0400, 1'h0, 1'h0, 21'h00_0000},
        '{1'h1, 16'hE5FE, 1'h0, 1'h0, 21'h00_0010, 1'h1, 1'h1, 21'h00_000C}};
    always #2.5 clock = ~clock;
    crbu_branch_unit u_dut (.clock(clock), .reset(reset), .clock_enable(1'b1), .instr(instr),
        .pc_incremented(pc), .flag_overflow(ovf), .flag_zero(zero), .phase(phase), .busy(busy),
        .is_branch(is_branch), .taken(taken), .nop_cycle(nop_cycle), .flush_fetch(flush_fetch),
        .pc_wr(pc_wr), .flags_write(flags_write));
    task automatic chk_bit(string n, logic e, logic g);
        n_tests++;
        if (g !== e) begin
            mismatches++;
            $display("MISMATCH %s expected %b seen %b", n, e, g);
        end
    endtask : chk_bit
    task automatic chk_pc(string n, logic [20:0] e, logic [20:0] g);
        n_tests++;
        if (g !== e) begin
            mismatches++;
            $display("MISMATCH %s expected %h seen %h", n, e, g);
        end
    endtask : chk_pc
    // One instruction aligned to a decode phase; extra is offered during the no-op cycle
    task automatic run(crbu_row_t r, logic [15:0] extra);
        do begin
            @(posedge clock);
            #1;
        end while (phase !== crbu_pkg::CRBU_PH_WRITE);
        @(posedge clock);
        instr <= {r.v, r.w};
        ovf <= r.o;
        zero <= r.z;
        pc <= r.pc;
        repeat (2) @(posedge clock);
        instr <= '0;
        @(posedge clock);
        #1;
        chk_bit("is_branch", r.br, is_branch);
        chk_bit("busy", r.br, busy);
        chk_bit("taken", r.tk, taken);
        if (r.tk) chk_pc("target", r.tg, pc_wr.target);
        @(posedge clock);
        instr <= {r.tk, extra};
        #1;
        chk_bit("pc_write", r.tk, pc_wr.write);
        chk_bit("flush_fetch", r.tk, flush_fetch);
        chk_bit("flags_write", 1'b0, flags_write);
        @(posedge clock);
        #1;
        chk_bit("pc_write_end", 1'b0, pc_wr.write);
        // A word decoded in the no-op cycle would clear the held condition result
        chk_bit("taken_hold", r.tk, taken);
        chk_bit("nop_cycle", r.tk, nop_cycle);
        @(posedge clock);
        instr <= '0;
    endtask : run
    task automatic finish_test();
        $display("Comparisons %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : finish_test
    // Watchdog well beyond the roughly one hundred cycles the sequence needs
    initial begin
        #20000;
        mismatches++;
        finish_test();
    end
    initial begin
        repeat (10) @(posedge clock);
        reset <= 1'b0;
        foreach (rows[i]) run(rows[i], 16'h0000);
        reset <= 1'b1;
        #1;
        chk_bit("nop_reset", 1'b0, nop_cycle);
        chk_bit("busy_reset", 1'b0, busy);
        chk_bit("decode_reset", 1'b1, phase == crbu_pkg::CRBU_PH_DECODE);
        repeat (2) @(posedge clock);
        reset <= 1'b0;
        // A taken branch word offered in the no-op cycle must be refused
        run(rows[0], 16'hE17F);
        repeat (2) @(posedge clock);
        #1;
        chk_bit("nop_refuse", 1'b0, pc_wr.write);
        finish_test();
    end
endmodule : crbu_branch_unit_tb

// File: crbu_chk.sv
`timescale 1ns/1ps
// Port watcher; expects clock_enable held high by the bench
module crbu_chk #(
    parameter int PC_W = 21
) (
    input wire logic clock,
    input wire logic reset,
    input wire logic clock_enable,
    input wire crbu_pkg::crbu_instr_t instr,
    input wire logic [PC_W-1:0] pc_incremented,
    input wire logic flag_overflow,
    input wire logic flag_zero,
    input wire crbu_pkg::crbu_phase_t phase,
    input wire logic is_branch,
    input wire logic taken,
    input wire logic nop_cycle,
    input wire logic flush_fetch,
    input wire crbu_pkg::crbu_pc_wr_t pc_wr,
    input wire logic flags_write
);
    default clocking @(posedge clock);
    endclocking
    default disable iff (reset);
    // Branch word accepted at a decode edge; no-op cycles refuse words
    wire logic op_v = instr.word[15:8] == crbu_pkg::OP_NO_OVERFLOW;
    wire logic op_z = instr.word[15:8] == crbu_pkg::OP_NONZERO;
    // The edge that still samples reset high does not step, so it is no decode edge
    wire logic dec_idle = !reset && clock_enable && phase == crbu_pkg::CRBU_PH_DECODE &&
        !nop_cycle;
    wire logic dec = dec_idle && instr.valid && (op_v || op_z);
    a_flags_untouched: assert property (flags_write == 1'b0)
        else $error("status flags written");
    a_phase_order: assert property (!reset && phase == crbu_pkg::CRBU_PH_DECODE |=>
        phase == crbu_pkg::CRBU_PH_LITERAL ##1 phase == crbu_pkg::CRBU_PH_PROCESS
        ##1 phase == crbu_pkg::CRBU_PH_WRITE) else $error("phase order broken");
    a_decode_branch: assert property (dec |=> is_branch)
        else $error("branch word not recognised");
    a_other_idle: assert property (dec_idle && !dec |=> !is_branch ##3 !pc_wr.write)
        else $error("other word acted on");
    a_ovf_cond: assert property (dec && op_v ##2 1 |=> taken == !$past(flag_overflow))
        else $error("overflow condition wrong");
    a_zero_cond: assert property (dec && op_z ##2 1 |=> taken == !$past(flag_zero))
        else $error("zero condition wrong");
    a_target_sum: assert property (dec ##3 1 |-> pc_wr.target == PC_W'($past(pc_incremented)
        + PC_W'($signed($past(instr.word[7:0], 3))) * 2)) else $error("target wrong");
    a_taken_write: assert property (dec ##3 taken |=> pc_wr.write && flush_fetch
        && nop_cycle ##1 !pc_wr.write) else $error("taken branch write wrong");
    a_untaken_skip: assert property (dec ##3 !taken |=> !pc_wr.write && !nop_cycle)
        else $error("untaken branch wrote pc");
    a_nop_length: assert property ($rose(nop_cycle) |-> nop_cycle[*4] ##1 !nop_cycle)
        else $error("no-op cycle length wrong");
endmodule : crbu_chk

bind crbu_branch_unit crbu_chk #(.PC_W(PC_W)) u_chk (.*);

// File: crbu_pkg.sv
package crbu_pkg;
    // ------------------------------------------------------------------
    // Encodings and widths
    // ------------------------------------------------------------------
    localparam int WORD_W = 16;
    localparam int PC_W = 21;
    localparam logic [7:0] OP_NO_OVERFLOW = 8'hE5;
    localparam logic [7:0] OP_NONZERO = 8'hE1;
    localparam int OP_HI = 15;
    localparam int OP_LO = 8;
    localparam int OFS_HI = 7;
    localparam int OFS_LO = 0;
    localparam logic [PC_W-1:0] PC_RESET = 21'h00_0000;

    // Four phases of an instruction cycle, Gray coded
    typedef enum logic [1:0] {
        CRBU_PH_DECODE = 2'b00,
        CRBU_PH_LITERAL = 2'b01,
        CRBU_PH_PROCESS = 2'b11,
        CRBU_PH_WRITE = 2'b10
    } crbu_phase_t;

    // Instruction word handed in by the fetch stage
    typedef struct packed {
        logic valid;
        logic [WORD_W-1:0] word;
    } crbu_instr_t;

    // Program counter write request
    typedef struct packed {
        logic write;
        logic [PC_W-1:0] target;
    } crbu_pc_wr_t;
endpackage : crbu_pkg

// File: crbu_target_adder.sv
`timescale 1ns/1ps
// Registered target adder: incremented PC plus doubled signed offset
module crbu_target_adder #(
    parameter int PC_W = 21
) (
    input wire logic clock,
    input wire logic reset,
    input wire logic clock_enable,
    input wire logic load,
    input wire logic [PC_W-1:0] pc_next,
    input wire logic [7:0] offset,
    output logic [PC_W-1:0] target
);
    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [PC_W-1:0] target;
    } crbu_add_state_t;

    crbu_add_state_t state_reg;
    crbu_add_state_t state_next;
    logic [PC_W-1:0] doubled;

    // Elaboration check: a doubled 8-bit offset needs nine bits plus a sign
    if (PC_W < 10) begin : g_pc_w_check
        $error("PC_W too small for offset range");
    end

    // Sign extend and double; wraps modulo the PC width like the core
    always_comb begin
        doubled = {{(PC_W-9){offset[7]}}, offset, 1'b0};
        state_next = state_reg;
        if (load) begin
            state_next.target = pc_next + doubled;
        end
    end

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            state_reg <= '0;
        end else if (clock_enable) begin
            state_reg <= state_next;
        end
    end

    assign target = state_reg.target;
endmodule : crbu_target_adder
